// *** verilog/vad_defs.vh ***
// Constants for the voice activity energy and predictor front end.
// Included by every design file of the block except the divider; holds definitions only.
`ifndef VAD_DEFS_VH
`define VAD_DEFS_VH

`define VAD_ORDER        8
`define VAD_NCOEF        9
`define VAD_FRAMES       4
`define VAD_FRAC         13
`define VAD_RAV_SHIFT    18
`define VAD_RVAD0_RST    6
`define VAD_RVAD1_RST    -4
`define VAD_RVAD2_RST    1
`define VAD_THVAD_RST    1000000
`define VAD_PTH          300000
`define VAD_PLEV         800000
`define VAD_FIXED_TH     800000
`define VAD_FAC          3
`define VAD_ADP          8
`define VAD_MARGIN       80000000
`define VAD_BURST_MIN    3
`define VAD_HANG_LEN     5

`endif

// *** verilog/vad_div.v ***
// Serial signed divider: quotient of a signed numerator by a positive denominator.
// Assumes start is a one-cycle pulse given only while idle; den of zero gives zero.
`timescale 1ns/1ps
`default_nettype none

module vad_div #(
    parameter NW = 72,
    parameter DW = 34,
    parameter QW = 32
) (
    input  wire                 clk,
    input  wire                 rst,
    input  wire                 start,
    input  wire signed [NW-1:0] num,
    input  wire        [DW-1:0] den,
    output reg                  done,
    output reg  signed [QW-1:0] quot
);

    reg  [NW-1:0] q_r;
    reg  [DW:0]   rem_r;
    reg  [DW-1:0] den_r;
    reg  [7:0]    cnt_r;
    reg           run_r;
    reg           neg_r;

    wire [DW:0]   rem_sh = {rem_r[DW-1:0], q_r[NW-1]};
    wire          fits   = rem_sh >= {1'b0, den_r};
    wire [NW-1:0] q_nxt  = {q_r[NW-2:0], fits};
    wire [NW-1:0] qmax   = {{(NW-QW+1){1'b0}}, {(QW-1){1'b1}}};
    wire [NW-1:0] q_sat  = (q_nxt > qmax) ? qmax : q_nxt;
    wire [QW-1:0] q_mag  = q_sat[QW-1:0];

    always @(posedge clk)
    begin
        if (rst)
        begin
            q_r   <= {NW{1'b0}};
            rem_r <= {(DW+1){1'b0}};
            den_r <= {DW{1'b0}};
            cnt_r <= 8'h00;
            run_r <= 1'b0;
            neg_r <= 1'b0;
            done  <= 1'b0;
            quot  <= {QW{1'b0}};
        end
        else
        begin
            done <= 1'b0;
            if (start)
            begin
                q_r   <= num[NW-1] ? (~num + 1'b1) : num;
                neg_r <= num[NW-1];
                rem_r <= {(DW+1){1'b0}};
                den_r <= den;
                cnt_r <= 8'h00;
                run_r <= 1'b1;
            end
            else if (run_r)
            begin
                rem_r <= fits ? (rem_sh - {1'b0, den_r}) : rem_sh;
                q_r   <= q_nxt;
                cnt_r <= cnt_r + 8'h01;
                if (cnt_r == NW - 1)
                begin
                    run_r <= 1'b0;
                    done  <= 1'b1;
                    // A zero energy means no usable spectrum, so the step is dropped.
                    if (den_r == {DW{1'b0}})
                        quot <= {QW{1'b0}};
                    else if (neg_r)
                        quot <= ~q_mag + 1'b1;
                    else
                        quot <= q_mag;
                end
            end
        end
    end

endmodule

`default_nettype wire

// *** verilog/vad_acf_avg.v ***
// Four-frame autocorrelation averaging with a four-frame delayed copy.
// Assumes upd is a one-cycle pulse, once per accepted frame.
`timescale 1ns/1ps
`default_nettype none
`include "vad_defs.vh"

module vad_acf_avg #(
    parameter ACF_W = 32,
    parameter AV_W  = 34
) (
    input  wire                         clk,
    input  wire                         rst,
    input  wire                         upd,
    input  wire [`VAD_NCOEF*ACF_W-1:0]  acf,
    output wire [`VAD_NCOEF*AV_W-1:0]   av_cur,
    output wire [`VAD_NCOEF*AV_W-1:0]   av_dly
);

    localparam NH = `VAD_FRAMES - 1;
    localparam NA = `VAD_FRAMES;

    genvar g;
    generate
        for (g = 0; g < `VAD_NCOEF; g = g + 1)
        begin : per_idx
            reg  signed [ACF_W-1:0] hist_r [0:NH-1];
            reg  signed [AV_W-1:0]  avh_r  [0:NA-1];
            reg  signed [AV_W-1:0]  cur_r;
            wire signed [ACF_W-1:0] x = acf[g*ACF_W +: ACF_W];
            wire signed [AV_W-1:0]  sum = {{(AV_W-ACF_W){x[ACF_W-1]}}, x}
                + {{(AV_W-ACF_W){hist_r[0][ACF_W-1]}}, hist_r[0]}
                + {{(AV_W-ACF_W){hist_r[1][ACF_W-1]}}, hist_r[1]}
                + {{(AV_W-ACF_W){hist_r[2][ACF_W-1]}}, hist_r[2]};
            integer n;

            always @(posedge clk)
            begin
                if (rst)
                begin
                    for (n = 0; n < NH; n = n + 1)
                        hist_r[n] <= {ACF_W{1'b0}};
                    for (n = 0; n < NA; n = n + 1)
                        avh_r[n] <= {AV_W{1'b0}};
                    cur_r <= {AV_W{1'b0}};
                end
                else if (upd)
                begin
                    cur_r     <= sum;
                    hist_r[0] <= x;
                    for (n = 1; n < NH; n = n + 1)
                        hist_r[n] <= hist_r[n-1];
                    // The oldest stored sum is the one from four frames before the new one.
                    avh_r[0] <= cur_r;
                    for (n = 1; n < NA; n = n + 1)
                        avh_r[n] <= avh_r[n-1];
                end
            end

            assign av_cur[g*AV_W +: AV_W] = cur_r;
            assign av_dly[g*AV_W +: AV_W] = avh_r[NA-1];
        end
    endgenerate

endmodule

`default_nettype wire

// *** verilog/vad_energy_predictor.v ***
// Per-frame voice activity front end: filtered energy, decision, averaging,
// predictor solve and predictor autocorrelation, adaptation and hangover.
// Assumes the encoder logic on the same clock gives one strobe per frame with
// the nine autocorrelation values, plus stationarity, pitch and tone flags.
//
// Behaviour
// - One speech or non-speech decision comes out for every accepted 20 ms frame.
// - Filtered energy is rvad0 times acf0 plus twice the sum of rvad_i times acf_i for i 1 to 8.
// - Speech is indicated whenever the filtered energy exceeds both the adaptive threshold and the fixed floor.
// - Each current averaged value is the sum of that index over this frame and three before.
// - The delayed average is the current average as it stood four frames earlier.
// - Reset clears the autocorrelation history and both averaged vectors.
// - Coefficients 1 to 8 solve the normal equations of the delayed average; coefficient 0 is -1.
// - Predictor autocorrelation i sums coefficient k times coefficient k+i over k 0 to 8-i.
// - Filter and scaled threshold adapt only without speech, with stationarity and no pitch.
// - No filter adaptation or scaled threshold update happens while a tone is reported.
// - A fixed energy floor keeps low-level unsteady noise from counting as speech.
// - Hangover frames follow only bursts of at least a set length.
`timescale 1ns/1ps
`default_nettype none
`include "vad_defs.vh"

module vad_energy_predictor #(
    parameter ACF_W     = 32,
    parameter CW        = 32,
    parameter BURST_MIN = `VAD_BURST_MIN,
    parameter HANG_LEN  = `VAD_HANG_LEN
) (
    input  wire                             clk,
    input  wire                             rst,
    input  wire                             frame_strobe,
    input  wire [`VAD_NCOEF*ACF_W-1:0]      frame_autocorr,
    input  wire                             stationary,
    input  wire                             pitch_present,
    input  wire                             tone_present,
    output reg                              vad_decision,
    output reg                              vad_raw,
    output reg                              decision_valid,
    output reg                              busy,
    output reg                              overrun,
    output reg  signed [2*ACF_W+7:0]        filtered_energy,
    output reg  [`VAD_NCOEF*CW-1:0]         predictor_autocorr,
    output wire [`VAD_NCOEF*(ACF_W+2)-1:0]  averaged_autocorr_current
);

    localparam AV_W = ACF_W + 2;
    localparam PW   = 2*ACF_W + 8;
    localparam NW   = CW + AV_W + 6;
    localparam EW   = CW + NW;
    localparam S_IDLE = 3'd0;
    localparam S_PV   = 3'd1;
    localparam S_DEC  = 3'd2;
    localparam S_NUM  = 3'd3;
    localparam S_DIV  = 3'd4;
    localparam S_UPD  = 3'd5;
    localparam S_RAV  = 3'd6;
    localparam S_ADP  = 3'd7;
    localparam signed [CW-1:0] ONE = 1 << `VAD_FRAC;
    localparam signed [PW-1:0] PTH     = `VAD_PTH;
    localparam signed [PW-1:0] PLEV    = `VAD_PLEV;
    localparam signed [PW-1:0] FIX_TH  = `VAD_FIXED_TH;
    localparam signed [PW-1:0] MARGIN  = `VAD_MARGIN;
    localparam signed [PW-1:0] TH_RST  = `VAD_THVAD_RST;
    localparam [3:0] ADP = `VAD_ADP;

    reg  [2:0]              state_r;
    reg  [3:0]              i_r;
    reg  [3:0]              j_r;
    reg  [3:0]              m_r;
    reg  [3:0]              adapt_cnt_r;
    reg  [7:0]              burst_r;
    reg  [7:0]              hang_r;
    reg                     stat_r;
    reg                     pitch_r;
    reg                     tone_r;
    reg                     div_start_r;
    reg  signed [NW-1:0]    acc_r;
    reg  signed [PW-1:0]    thvad_r;
    reg  [AV_W-1:0]         e_r;
    reg  signed [CW-1:0]    k_r;
    reg  signed [ACF_W-1:0] acf_r  [0:`VAD_ORDER];
    reg  signed [CW-1:0]    rvad_r [0:`VAD_ORDER];
    reg  signed [CW-1:0]    coef_r [0:`VAD_ORDER];
    reg  signed [CW-1:0]    tmp_r  [0:`VAD_ORDER];
    wire signed [AV_W-1:0]  av1_w  [0:`VAD_ORDER];
    wire [`VAD_NCOEF*AV_W-1:0] av_dly;
    wire                    div_done;
    wire signed [CW-1:0]    div_q;
    integer n;

    // A strobe during the computation is dropped so the history stays frame-true.
    wire accept = frame_strobe && (state_r == S_IDLE);

    vad_acf_avg #(
        .ACF_W (ACF_W),
        .AV_W  (AV_W)
    ) u_avg (
        .clk    (clk),
        .rst    (rst),
        .upd    (accept),
        .acf    (frame_autocorr),
        .av_cur (averaged_autocorr_current),
        .av_dly (av_dly)
    );

    vad_div #(
        .NW (NW),
        .DW (AV_W),
        .QW (CW)
    ) u_div (
        .clk   (clk),
        .rst   (rst),
        .start (div_start_r),
        .num   (acc_r),
        .den   (e_r),
        .done  (div_done),
        .quot  (div_q)
    );

    genvar g;
    generate
        for (g = 0; g < `VAD_NCOEF; g = g + 1)
        begin : unpack
            assign av1_w[g] = av_dly[g*AV_W +: AV_W];
        end
    endgenerate

    wire signed [2*ACF_W-1:0] pv_prod  = rvad_r[i_r] * acf_r[i_r];
    wire signed [PW-1:0]      pv_ext   = {{(PW-2*ACF_W){pv_prod[2*ACF_W-1]}}, pv_prod};
    wire signed [PW-1:0]      pv_term  = (i_r == 4'd0) ? pv_ext : (pv_ext <<< 1);
    wire signed [CW+AV_W-1:0] ld_prod  = coef_r[j_r] * av1_w[m_r - j_r];
    wire signed [NW-1:0]      ld_ext   = {{(NW-CW-AV_W){ld_prod[CW+AV_W-1]}}, ld_prod};
    wire signed [NW-1:0]      r_init   = {{(NW-AV_W){av1_w[m_r + 4'h1][AV_W-1]}}, av1_w[m_r + 4'h1]};
    wire signed [2*CW-1:0]    up_prod  = k_r * tmp_r[m_r - j_r];
    wire signed [2*CW-1:0]    up_sh    = up_prod >>> `VAD_FRAC;
    wire signed [NW-1:0]      num_sh   = acc_r >>> `VAD_FRAC;
    wire signed [EW-1:0]      e_prod   = k_r * num_sh;
    wire signed [EW-1:0]      e_new    = $signed({{(EW-AV_W){1'b0}}, e_r})
                                         - (e_prod >>> `VAD_FRAC);
    wire signed [2*CW-1:0]    rav_prod = coef_r[j_r] * coef_r[j_r + i_r];
    wire signed [NW-1:0]      rav_sum  = acc_r + {{(NW-2*CW){rav_prod[2*CW-1]}}, rav_prod};
    wire signed [NW-1:0]      rav_sh   = rav_sum >>> `VAD_RAV_SHIFT;
    wire signed [PW-1:0]      pvad     = acc_r[PW-1:0];
    wire signed [PW-1:0]      acf0_ext = {{(PW-ACF_W){acf_r[0][ACF_W-1]}}, acf_r[0]};
    wire signed [PW-1:0]      th_fac   = pvad * `VAD_FAC;
    wire signed [PW-1:0]      th_cap   = pvad + MARGIN;
    wire speech = (pvad > thvad_r) && (pvad > FIX_TH);
    wire adapt_ok = !vad_raw && stat_r && !pitch_r && !tone_r;

    always @(posedge clk)
    begin
        if (rst)
        begin
            state_r        <= S_IDLE;
            i_r            <= 4'h0;
            j_r            <= 4'h0;
            m_r            <= 4'h0;
            adapt_cnt_r    <= 4'h0;
            burst_r        <= 8'h00;
            hang_r         <= 8'h00;
            stat_r         <= 1'b0;
            pitch_r        <= 1'b0;
            tone_r         <= 1'b0;
            div_start_r    <= 1'b0;
            acc_r          <= {NW{1'b0}};
            thvad_r        <= TH_RST;
            e_r            <= {AV_W{1'b0}};
            k_r            <= {CW{1'b0}};
            vad_decision   <= 1'b0;
            vad_raw        <= 1'b0;
            decision_valid <= 1'b0;
            busy           <= 1'b0;
            overrun        <= 1'b0;
            filtered_energy    <= {PW{1'b0}};
            predictor_autocorr <= {(`VAD_NCOEF*CW){1'b0}};
            for (n = 0; n <= `VAD_ORDER; n = n + 1)
            begin
                acf_r[n]  <= {ACF_W{1'b0}};
                rvad_r[n] <= {CW{1'b0}};
                coef_r[n] <= {CW{1'b0}};
                tmp_r[n]  <= {CW{1'b0}};
            end
            rvad_r[0] <= `VAD_RVAD0_RST;
            rvad_r[1] <= `VAD_RVAD1_RST;
            rvad_r[2] <= `VAD_RVAD2_RST;
        end
        else
        begin
            decision_valid <= 1'b0;
            div_start_r    <= 1'b0;
            overrun        <= frame_strobe && (state_r != S_IDLE);
            case (state_r)
                S_IDLE:
                begin
                    if (accept)
                    begin
                        for (n = 0; n <= `VAD_ORDER; n = n + 1)
                            acf_r[n] <= frame_autocorr[n*ACF_W +: ACF_W];
                        stat_r  <= stationary;
                        pitch_r <= pitch_present;
                        tone_r  <= tone_present;
                        acc_r   <= {NW{1'b0}};
                        i_r     <= 4'h0;
                        busy    <= 1'b1;
                        state_r <= S_PV;
                    end
                end
                S_PV:
                begin
                    acc_r <= acc_r + {{(NW-PW){pv_term[PW-1]}}, pv_term};
                    i_r   <= i_r + 4'h1;
                    if (i_r == `VAD_ORDER)
                        state_r <= S_DEC;
                end
                S_DEC:
                begin
                    filtered_energy <= pvad;
                    vad_raw         <= speech;
                    decision_valid  <= 1'b1;
                    if (speech)
                    begin
                        burst_r      <= (burst_r == 8'hff) ? burst_r : burst_r + 8'h01;
                        vad_decision <= 1'b1;
                        // Short spikes end without hangover; only long bursts arm it.
                        if (burst_r + 8'h01 >= BURST_MIN)
                            hang_r <= HANG_LEN[7:0];
                    end
                    else
                    begin
                        burst_r      <= 8'h00;
                        vad_decision <= (hang_r != 8'h00);
                        if (hang_r != 8'h00)
                            hang_r <= hang_r - 8'h01;
                    end
                    coef_r[0] <= -ONE;
                    for (n = 1; n <= `VAD_ORDER; n = n + 1)
                        coef_r[n] <= {CW{1'b0}};
                    e_r     <= av1_w[0][AV_W-1] ? {AV_W{1'b0}} : av1_w[0];
                    m_r     <= 4'h1;
                    j_r     <= 4'h1;
                    acc_r   <= {{(NW-AV_W){av1_w[1][AV_W-1]}}, av1_w[1]} <<< `VAD_FRAC;
                    state_r <= S_NUM;
                end
                S_NUM:
                begin
                    if (j_r == m_r)
                    begin
                        div_start_r <= 1'b1;
                        for (n = 0; n <= `VAD_ORDER; n = n + 1)
                            tmp_r[n] <= coef_r[n];
                        state_r <= S_DIV;
                    end
                    else
                    begin
                        // The predicted part is taken off the correlation to leave the error.
                        acc_r <= acc_r - ld_ext;
                        j_r   <= j_r + 4'h1;
                    end
                end
                S_DIV:
                begin
                    if (div_done)
                    begin
                        k_r     <= div_q;
                        j_r     <= 4'h1;
                        state_r <= S_UPD;
                    end
                end
                S_UPD:
                begin
                    if (j_r == m_r)
                    begin
                        coef_r[m_r] <= k_r;
                        e_r <= (e_new > 0) ? e_new[AV_W-1:0] : {AV_W{1'b0}};
                        if (m_r == `VAD_ORDER)
                        begin
                            i_r     <= 4'h0;
                            j_r     <= 4'h0;
                            acc_r   <= {NW{1'b0}};
                            state_r <= S_RAV;
                        end
                        else
                        begin
                            m_r     <= m_r + 4'h1;
                            j_r     <= 4'h1;
                            acc_r   <= r_init <<< `VAD_FRAC;
                            state_r <= S_NUM;
                        end
                    end
                    else
                    begin
                        coef_r[j_r] <= tmp_r[j_r] - up_sh[CW-1:0];
                        j_r <= j_r + 4'h1;
                    end
                end
                S_RAV:
                begin
                    if (j_r + i_r == `VAD_ORDER)
                    begin
                        predictor_autocorr[i_r*CW +: CW] <= rav_sh[CW-1:0];
                        acc_r <= {NW{1'b0}};
                        j_r   <= 4'h0;
                        i_r   <= i_r + 4'h1;
                        if (i_r == `VAD_ORDER)
                        begin
                            acc_r   <= {{(NW-PW){filtered_energy[PW-1]}}, filtered_energy};
                            state_r <= S_ADP;
                        end
                    end
                    else
                    begin
                        acc_r <= rav_sum;
                        j_r   <= j_r + 4'h1;
                    end
                end
                S_ADP:
                begin
                    busy    <= 1'b0;
                    state_r <= S_IDLE;
                    if (!vad_raw && acf0_ext < PTH)
                    begin
                        thvad_r     <= PLEV;
                        adapt_cnt_r <= 4'h0;
                    end
                    else if (adapt_ok)
                    begin
                        adapt_cnt_r <= (adapt_cnt_r == ADP) ? ADP : adapt_cnt_r + 4'h1;
                        if (adapt_cnt_r + 4'h1 >= ADP)
                        begin
                            thvad_r <= (th_fac < th_cap) ? th_fac : th_cap;
                            for (n = 0; n <= `VAD_ORDER; n = n + 1)
                                rvad_r[n] <= predictor_autocorr[n*CW +: CW];
                        end
                    end
                    else
                        adapt_cnt_r <= 4'h0;
                end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

endmodule

`default_nettype wire

// *** test/vad_enc_model.sv ***
// Encoder stand-in: presents one autocorrelation vector and its flags per strobe.
// Assumes the block samples them at the rising edge while the strobe is high.
`timescale 1ns/1ps
`default_nettype none
module vad_enc_model (
    input  wire logic    clk,
    input  wire logic    busy,
    output logic         frame_strobe,
    output logic [287:0] frame_autocorr,
    output logic         stationary,
    output logic         pitch_present,
    output logic         tone_present
);
    initial
    begin
        frame_strobe = 1'b0;
        frame_autocorr = 288'h0;
        {stationary, pitch_present, tone_present} = 3'h0;
    end
    task automatic send(input longint a0, a1, a2, input logic [2:0] fl, input bit early);
        int n;
        n = 0;
        @(negedge clk);
        while (busy !== 1'b0 && !early && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        frame_strobe = 1'b1;
        frame_autocorr = {192'h0, a2[31:0], a1[31:0], a0[31:0]};
        {stationary, pitch_present, tone_present} = fl;
        @(negedge clk);
        frame_strobe = 1'b0;
        // Released lines flip so that a late sample cannot pass unseen.
        frame_autocorr = ~frame_autocorr;
        {stationary, pitch_present, tone_present} = ~fl;
    endtask
endmodule
`default_nettype wire

// *** test/vad_checker_asserts.sv ***
// Timing checks on the ports of the voice activity front end.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
`include "vad_defs.vh"
module vad_checker #(
    parameter ACF_W = 32
) (
    input wire logic                            clk,
    input wire logic                            rst,
    input wire logic                            frame_strobe,
    input wire logic                            busy,
    input wire logic                            decision_valid,
    input wire logic                            overrun,
    input wire logic                            vad_decision,
    input wire logic                            vad_raw,
    input wire logic signed [2*ACF_W+7:0]       filtered_energy,
    input wire logic [`VAD_NCOEF*(ACF_W+2)-1:0] averaged_autocorr_current
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire accept = frame_strobe & ~busy;
    sequence s_accept;
        accept;
    endsequence
    sequence s_answer;
        ##11 decision_valid;
    endsequence
    a_answer_time: assert property (s_accept |-> s_answer)
        else $error("decision late");
    a_answer_cause: assert property (decision_valid |-> $past(accept, 11))
        else $error("decision without strobe");
    a_valid_pulse: assert property (decision_valid |=> !decision_valid)
        else $error("valid too long");
    a_outputs_stand: assert property (!decision_valid |-> $stable(vad_decision) &&
        $stable(vad_raw) && $stable(filtered_energy)) else $error("output moved");
    a_floor_held: assert property (decision_valid && vad_raw |->
        filtered_energy > `VAD_FIXED_TH) else $error("speech below floor");
    a_hang_adds: assert property (decision_valid && vad_raw |-> vad_decision)
        else $error("speech dropped");
    a_busy_start: assert property (s_accept |=> busy)
        else $error("busy missing");
    a_overrun_flag: assert property (frame_strobe && busy |=> overrun)
        else $error("overrun missing");
    a_overrun_only: assert property (overrun |-> $past(frame_strobe) && $past(busy))
        else $error("stray overrun");
    a_avg_hold: assert property (!$past(accept) |-> $stable(averaged_autocorr_current))
        else $error("average moved");
    a_reset_clear: assert property ($fell(rst) |-> averaged_autocorr_current == '0)
        else $error("average not cleared");
endmodule
bind vad_energy_predictor vad_checker #(.ACF_W(ACF_W)) u_checker (.clk(clk), .rst(rst),
    .frame_strobe(frame_strobe), .busy(busy), .decision_valid(decision_valid),
    .overrun(overrun), .vad_decision(vad_decision), .vad_raw(vad_raw),
    .filtered_energy(filtered_energy), .averaged_autocorr_current(averaged_autocorr_current));
`default_nettype wire

// *** test/vad_energy_predictor_tb.sv ***
// Self-checking bench for the voice activity front end with an encoder stand-in.
// Assumes the design header is on the include path.
`timescale 1ns/1ps
`default_nettype none
`include "vad_defs.vh"
module vad_energy_predictor_tb;
    logic               clk, rst, frame_strobe, stationary, pitch_present, tone_present;
    logic               vad_decision, vad_raw, decision_valid, busy, overrun;
    logic [287:0]       frame_autocorr, predictor_autocorr;
    logic signed [71:0] filtered_energy;
    logic [305:0]       averaged_autocorr_current;
    int                 failures, n_checks, run, hang;
    longint             th, h0[$], h1[$];
    bit                 adapted;
    vad_energy_predictor DUT (.clk(clk), .rst(rst), .frame_strobe(frame_strobe),
        .frame_autocorr(frame_autocorr), .stationary(stationary),
        .pitch_present(pitch_present), .tone_present(tone_present),
        .vad_decision(vad_decision), .vad_raw(vad_raw), .decision_valid(decision_valid),
        .busy(busy), .overrun(overrun), .filtered_energy(filtered_energy),
        .predictor_autocorr(predictor_autocorr),
        .averaged_autocorr_current(averaged_autocorr_current));
    vad_enc_model u_enc (.clk(clk), .busy(busy), .frame_strobe(frame_strobe),
        .frame_autocorr(frame_autocorr), .stationary(stationary),
        .pitch_present(pitch_present), .tone_present(tone_present));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [71:0] got, exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Tracks threshold and hangover only while the filter keeps its reset shape.
    task automatic frame(input longint a0, a1, a2, input logic [2:0] fl);
        longint e;
        int n;
        bit sp, dec;
        e = 6 * a0 - 8 * a1 + 2 * a2;
        sp = e > th && e > `VAD_FIXED_TH;
        run = sp ? run + 1 : 0;
        if (sp && run >= 3)
            hang = 5;
        dec = sp || hang > 0;
        if (!sp && hang > 0)
            hang--;
        if (!sp && a0 < `VAD_PTH)
            th = `VAD_PLEV;
        h0.push_front(a0);
        h1.push_front(a1);
        if (h0.size() > 4)
        begin
            void'(h0.pop_back());
            void'(h1.pop_back());
        end
        u_enc.send(a0, a1, a2, fl, 1'b0);
        n = 0;
        while (decision_valid !== 1'b1 && n < 50)
        begin
            @(negedge clk);
            n++;
        end
        chk(n, 10);
        chk(averaged_autocorr_current[0 +: 34], h0.sum());
        chk(averaged_autocorr_current[34 +: 34], h1.sum());
        if (!adapted)
        begin
            chk(filtered_energy, e);
            chk(vad_raw, sp);
            chk(vad_decision, dec);
        end
        n = 0;
        while (busy !== 1'b0 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
        chk(busy, 1'b0);
    endtask
    task automatic t_reset;
        @(negedge clk);
        chk(averaged_autocorr_current[71:0], 72'h0);
        chk({busy, vad_decision, decision_valid, overrun}, 4'h0);
    endtask
    task automatic t_predictor;
        for (int k = 0; k < 5; k++)
        begin
            frame(1000000, 500000, 0, 3'h0);
            if (k < 4)
                chk(predictor_autocorr[71:0], 72'h100);
            else
                chk(predictor_autocorr[63], 1'b1);
        end
    endtask
    task automatic t_overrun;
        fork
            frame(1000000, 0, 0, 3'h0);
            begin
                repeat (3) @(negedge clk);
                u_enc.send(5000000, 7, 7, 3'h0, 1'b1);
                chk(overrun, 1'b1);
            end
        join
        frame(1000000, 0, 0, 3'h0);
    endtask
    task automatic t_no_adapt;
        repeat (9) frame(300000, 150000, 0, 3'h5);
        repeat (9) frame(300000, 150000, 0, 3'h6);
        repeat (9) frame(1000000, 0, 0, 3'h4);
    endtask
    task automatic t_hangover;
        repeat (7) frame(100000, 0, 0, 3'h0);
        repeat (2) frame(1000000, 0, 0, 3'h0);
        repeat (2) frame(100000, 0, 0, 3'h0);
        repeat (3) frame(1000000, 0, 0, 3'h0);
        repeat (6) frame(100000, 0, 0, 3'h0);
    endtask
    task automatic t_adapt;
        repeat (8) frame(300000, 150000, 0, 3'h4);
        adapted = 1'b1;
        frame(300000, 150000, 0, 3'h4);
        chk(filtered_energy != 72'sd600000, 1'b1);
    endtask
    initial
    begin
        rst = 1'b1;
        {failures, n_checks, run, hang, adapted} = '0;
        th = `VAD_THVAD_RST;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        t_reset;
        t_predictor;
        t_overrun;
        t_no_adapt;
        t_hangover;
        t_adapt;
        close_out;
    end
    // The whole run needs well under this many cycles.
    initial
    begin
        repeat (100000) @(posedge clk);
        failures++;
        close_out;
    end
endmodule
`default_nettype wire
